// [hdl/ccl_pkg.sv]
// Package: register map, field layout, codes and carriers of the comparator control block
package ccl_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CMP_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CONV_B    = 8'h04;
  localparam logic [7:0] OFF_DIN_DIS   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  // ==========================================================
  // Field positions
  localparam int BIT_OFF      = 7;
  localparam int BIT_REF      = 6;
  localparam int BIT_RES      = 5;
  localparam int BIT_FLAG     = 4;
  localparam int BIT_IEN      = 3;
  localparam int BIT_RSV      = 2;
  localparam int MODE_LSB     = 0;
  localparam int BIT_MUXEN    = 6;
  localparam int BIT_NEG_OFF  = 1;
  localparam int BIT_POS_OFF  = 0;
  localparam int IRQ_EVT      = 0;
  localparam int IRQ_TOG      = 1;
  localparam int IRQ_W        = 2;
  // ==========================================================
  // Edge mode codes
  typedef logic [1:0] ccl_mode_t;
  localparam ccl_mode_t MODE_TOGGLE = 2'h0;
  localparam ccl_mode_t MODE_RSVD   = 2'h1;
  localparam ccl_mode_t MODE_FALL   = 2'h2;
  localparam ccl_mode_t MODE_RISE   = 2'h3;
  // ==========================================================
  // Reset values, bus answers, timing
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
  localparam logic [1:0]        DIS_RST     = 2'h0;
  localparam logic [IRQ_W-1:0]  MASK_RST    = 2'h0;
  localparam int                SYNC_STAGES = 2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       power_off;
    logic       ref_bandgap;
    logic       neg_from_mux;
    logic [1:0] neg_channel;
  } ccl_analog_s;
  typedef struct packed {
    logic neg;
    logic pos;
  } ccl_pins_s;
endpackage

// [hdl/ccl_sync.sv]
// Level synchroniser for the raw comparator output
`timescale 1ns/1ps
module ccl_sync #(
  parameter int STAGES = ccl_pkg::SYNC_STAGES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  // ==========================================================
  // Shift chain; only the last stage is seen outside
  logic [STAGES-1:0] stage_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = stage_q[STAGES-1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sync_latency_a: assert property (##STAGES sync_out == $past(async_in, STAGES))
    else $error("synchronised output does not follow input after fixed latency");
endmodule

// [hdl/ccl_edge.sv]
// Edge detector choosing the comparator event by mode
`timescale 1ns/1ps
module ccl_edge (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              level,
  input  wire logic              hold_off,
  input  wire ccl_pkg::ccl_mode_t mode,
  output logic                   event_pulse,
  output logic                   toggle_pulse
);
  // ==========================================================
  // Previous value keeps tracking while held off, so no stale edge fires on release
  logic prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise         = level & ~prev_q & ~hold_off;
  assign fall         = ~level & prev_q & ~hold_off;
  assign toggle_pulse = rise | fall;

  always_comb begin
    case (mode)
      ccl_pkg::MODE_TOGGLE: event_pulse = rise | fall;
      ccl_pkg::MODE_FALL:   event_pulse = fall;
      ccl_pkg::MODE_RISE:   event_pulse = rise;
      default:              event_pulse = 1'b0; // Reserved code raises nothing
    endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rise_mode_a: assert property (event_pulse && mode == ccl_pkg::MODE_RISE |-> $rose(level))
    else $error("rise mode event without rising level");
  hold_off_a: assert property (hold_off |-> !event_pulse && !toggle_pulse)
    else $error("event while detection held off");
  rsvd_mode_a: assert property (mode == ccl_pkg::MODE_RSVD |-> !event_pulse)
    else $error("reserved mode raised an event");
endmodule

// [hdl/ccl_top.sv]
// Comparator control: result sync, event flag, mux routing, pin gating, AXI4-Lite registers
//
// Contract
// - Result reads one while selected positive input exceeds selected negative input.
// - Raw comparator output is synchronised, two clocks latency.
// - Mode field picks toggle, reserved, falling or rising edge as event.
// - Hardware sets the event flag on the selected event.
// - Flag clears on vector execution or software writing one; zero leaves it.
// - Interrupt request only while flag, enable and global enable all set.
// - Writing the off bit powers down the comparator, allowed any time.
// - Fixed reference bit selects bandgap, else positive pin, for positive input.
// - Control register bit 2 always reads zero.
// - Mux enable with converter off routes channel 0 to 3 to negative input.
// - Mux enable sits at bit 6 of converter register B, read-write.
// - Input-off bits disable pin buffers and force port input reads to zero.
// - While converter is on it owns the mux; comparator cannot borrow it.
`timescale 1ns/1ps
module ccl_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Comparator core and converter side
  input  wire logic                 cmp_raw,
  input  wire logic                 converter_on,
  input  wire logic [1:0]           channel_select,
  output ccl_pkg::ccl_analog_s      analog_ctl,
  // Digital pin path
  input  wire ccl_pkg::ccl_pins_s   pin_in,
  output ccl_pkg::ccl_pins_s        pin_port,
  // Processor interrupt side
  input  wire logic                 global_irq_enable,
  input  wire logic                 irq_vector_ack,
  output logic                      comparator_irq_req,
  output logic                      irq
);
  // ==========================================================
  // Register state
  logic                    off_q;
  logic                    ref_q;
  logic                    ien_q;
  ccl_pkg::ccl_mode_t      mode_q;
  logic                    flag_q;
  logic                    muxen_q;
  logic [1:0]              dis_q;
  logic [ccl_pkg::IRQ_W-1:0] stat_q;
  logic [ccl_pkg::IRQ_W-1:0] mask_q;
  ccl_pkg::ccl_analog_s    analog_q;
  ccl_pkg::ccl_pins_s      pin_q;

  logic                    comparator_result;
  logic                    evt;
  logic                    tog;

  // ==========================================================
  // Bus handshake state
  logic                    aw_full_q;
  logic [7:0]              aw_addr_q;
  logic                    w_full_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  logic                    wr_go;
  logic                    rd_go;
  logic                    wr_ctrl;
  logic                    flag_clr;
  logic                    stat_clr;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == ccl_pkg::OFF_CMP_CTRL || a == ccl_pkg::OFF_CONV_B || a == ccl_pkg::OFF_DIN_DIS
          || a == ccl_pkg::OFF_IRQ_STAT || a == ccl_pkg::OFF_IRQ_MASK;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic [3:0] strb);
    hit = a == off && strb[0];
  endfunction

  // ==========================================================
  // Comparator output path
  ccl_sync #(
    .STAGES   (ccl_pkg::SYNC_STAGES)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (cmp_raw),
    .sync_out (comparator_result)
  );

  ccl_edge u_edge (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .level        (comparator_result),
    .hold_off     (off_q),
    .mode         (mode_q),
    .event_pulse  (evt),
    .toggle_pulse (tog)
  );

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign wr_go         = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ctrl       = wr_go && hit(aw_addr_q, ccl_pkg::OFF_CMP_CTRL, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ccl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(aw_addr_q) ? ccl_pkg::RESP_OKAY : ccl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================
  // Control fields; power down takes effect whatever else is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_q  <= 1'b0;
      ref_q  <= 1'b0;
      ien_q  <= 1'b0;
      mode_q <= ccl_pkg::MODE_TOGGLE;
    end else if (wr_ctrl) begin
      off_q  <= w_data_q[ccl_pkg::BIT_OFF];
      ref_q  <= w_data_q[ccl_pkg::BIT_REF];
      ien_q  <= w_data_q[ccl_pkg::BIT_IEN];
      mode_q <= w_data_q[ccl_pkg::MODE_LSB+1:ccl_pkg::MODE_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      muxen_q <= 1'b0;
      dis_q   <= ccl_pkg::DIS_RST;
      mask_q  <= ccl_pkg::MASK_RST;
    end else if (wr_go) begin
      if (hit(aw_addr_q, ccl_pkg::OFF_CONV_B, w_strb_q)) begin
        muxen_q <= w_data_q[ccl_pkg::BIT_MUXEN];
      end
      if (hit(aw_addr_q, ccl_pkg::OFF_DIN_DIS, w_strb_q)) begin
        dis_q <= w_data_q[ccl_pkg::BIT_NEG_OFF:ccl_pkg::BIT_POS_OFF];
      end
      if (hit(aw_addr_q, ccl_pkg::OFF_IRQ_MASK, w_strb_q)) begin
        mask_q <= w_data_q[ccl_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Event flag: a new event wins over a clear in the same cycle
  assign flag_clr = irq_vector_ack || (wr_ctrl && w_data_q[ccl_pkg::BIT_FLAG]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= evt || (flag_q && !flag_clr);
    end
  end

  assign comparator_irq_req = flag_q && ien_q && global_irq_enable;

  // ==========================================================
  // Sticky status, cleared by reading it; set wins over the read
  assign stat_clr = rd_go && s_axi_araddr == ccl_pkg::OFF_IRQ_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q[ccl_pkg::IRQ_EVT] <= evt || (stat_q[ccl_pkg::IRQ_EVT] && !stat_clr);
      stat_q[ccl_pkg::IRQ_TOG] <= tog || (stat_q[ccl_pkg::IRQ_TOG] && !stat_clr);
    end
  end

  assign irq = |(stat_q & mask_q);

  // ==========================================================
  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= ccl_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= 32'h00000000;
      rresp_q  <= mapped(s_axi_araddr) ? ccl_pkg::RESP_OKAY : ccl_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        ccl_pkg::OFF_CMP_CTRL: begin
          rdata_q[ccl_pkg::BIT_OFF]  <= off_q;
          rdata_q[ccl_pkg::BIT_REF]  <= ref_q;
          rdata_q[ccl_pkg::BIT_RES]  <= comparator_result;
          rdata_q[ccl_pkg::BIT_FLAG] <= flag_q;
          rdata_q[ccl_pkg::BIT_IEN]  <= ien_q;
          rdata_q[ccl_pkg::MODE_LSB+1:ccl_pkg::MODE_LSB] <= mode_q; // bit 2 left zero
        end
        ccl_pkg::OFF_CONV_B:   rdata_q[ccl_pkg::BIT_MUXEN] <= muxen_q;
        ccl_pkg::OFF_DIN_DIS:  rdata_q[ccl_pkg::BIT_NEG_OFF:ccl_pkg::BIT_POS_OFF] <= dis_q;
        ccl_pkg::OFF_IRQ_STAT: rdata_q[ccl_pkg::IRQ_W-1:0] <= stat_q;
        ccl_pkg::OFF_IRQ_MASK: rdata_q[ccl_pkg::IRQ_W-1:0] <= mask_q;
        default:               rdata_q <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ==========================================================
  // Analog routing; the converter owning the mux overrides the borrow request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_q <= '0;
    end else begin
      analog_q.power_off    <= off_q;
      analog_q.ref_bandgap  <= ref_q;
      analog_q.neg_from_mux <= muxen_q && !converter_on;
      analog_q.neg_channel  <= channel_select;
    end
  end

  assign analog_ctl = analog_q;

  // ==========================================================
  // Digital pin path; gated pins read zero and save buffer current
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '0;
    end else begin
      pin_q.neg <= pin_in.neg && !dis_q[ccl_pkg::BIT_NEG_OFF];
      pin_q.pos <= pin_in.pos && !dis_q[ccl_pkg::BIT_POS_OFF];
    end
  end

  assign pin_port = pin_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rd_ctrl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ctrl_q <= 1'b0;
    end else if (rd_go) begin
      rd_ctrl_q <= s_axi_araddr == ccl_pkg::OFF_CMP_CTRL;
    end
  end

  flag_set_a: assert property (evt |=> flag_q)
    else $error("event did not set flag");
  flag_clear_a: assert property (flag_clr && !evt |=> !flag_q)
    else $error("flag not cleared by ack or write one");
  flag_keep_a: assert property (wr_ctrl && !w_data_q[ccl_pkg::BIT_FLAG] && !irq_vector_ack && flag_q
                                |=> flag_q)
    else $error("writing zero cleared the flag");
  req_gate_a: assert property (comparator_irq_req |-> flag_q && ien_q && global_irq_enable)
    else $error("request without flag, enable and global enable");
  power_off_a: assert property (wr_ctrl && w_data_q[ccl_pkg::BIT_OFF] |=> ##1 analog_ctl.power_off)
    else $error("off write did not power down comparator");
  ref_route_a: assert property (##1 analog_ctl.ref_bandgap == $past(ref_q))
    else $error("positive input source does not follow fixed reference bit");
  mux_owner_a: assert property (converter_on |=> !analog_ctl.neg_from_mux)
    else $error("comparator borrowed mux while converter on");
  mux_route_a: assert property (muxen_q && !converter_on |=> analog_ctl.neg_from_mux
                                && analog_ctl.neg_channel == $past(channel_select))
    else $error("mux channel not routed to negative input");
  rsv_zero_a: assert property (s_axi_rvalid && rd_ctrl_q |-> !s_axi_rdata[ccl_pkg::BIT_RSV])
    else $error("reserved control bit read as one");
  muxen_rw_a: assert property (wr_go && hit(aw_addr_q, ccl_pkg::OFF_CONV_B, w_strb_q)
                               |=> muxen_q == $past(w_data_q[ccl_pkg::BIT_MUXEN]))
    else $error("mux enable write not stored");
  pin_gate_a: assert property (dis_q[ccl_pkg::BIT_POS_OFF] |=> !pin_port.pos)
    else $error("disabled positive pin did not read zero");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                 && !bvalid_q |=> ##1 s_axi_bvalid)
    else $error("write answer not given two cycles after take");

  rise_evt_c: cover property (mode_q == ccl_pkg::MODE_RISE && evt);
  irq_req_c: cover property (comparator_irq_req ##1 irq_vector_ack ##1 !flag_q);
  stat_read_c: cover property (stat_clr && |stat_q);
endmodule

// [testbench/ccl_cmp_model.sv]
// Behavioural model of the comparator core and its analog inputs
`timescale 1ns/1ps
module ccl_cmp_model #(
  parameter logic [7:0] BANDGAP_V = 8'h6E
) (
  input  wire ccl_pkg::ccl_analog_s analog_ctl,
  input  wire logic [7:0]           pos_v,
  input  wire logic [7:0]           neg_v,
  input  wire logic [31:0]          chan_v,
  output logic                      cmp_raw
);
  logic [7:0] p_sel;
  logic [7:0] n_sel;
  // ==========================================================
  // Input selection and compare
  always_comb begin
    p_sel = analog_ctl.ref_bandgap ? BANDGAP_V : pos_v;
    n_sel = analog_ctl.neg_from_mux ? chan_v[analog_ctl.neg_channel*8 +: 8] : neg_v;
    // An unpowered core parks its output low, so no compare runs
    cmp_raw = !analog_ctl.power_off && (p_sel > n_sel);
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] convb;
    logic       on;
    logic [1:0] ch;
    logic [7:0] pos;
    logic [2:0] an;
    logic       res;
  } ccl_row_s;
  localparam ccl_row_s ROWS [8] = '{
    '{8'h00, 8'h00, 1'b0, 2'h0, 8'h60, 3'h0, 1'b1}, '{8'h40, 8'h00, 1'b0, 2'h0, 8'h00, 3'h2, 1'b1},
    '{8'h00, 8'h40, 1'b0, 2'h2, 8'h35, 3'h1, 1'b1}, '{8'h00, 8'h40, 1'b0, 2'h3, 8'h25, 3'h1, 1'b0},
    '{8'h00, 8'h40, 1'b1, 2'h3, 8'h45, 3'h0, 1'b0}, '{8'h00, 8'h40, 1'b0, 2'h1, 8'h25, 3'h1, 1'b1},
    '{8'h00, 8'h40, 1'b0, 2'h0, 8'h05, 3'h1, 1'b0}, '{8'h00, 8'h00, 1'b0, 2'h0, 8'h45, 3'h0, 1'b0}};
  logic                 aclk, aresetn, cmp_raw, converter_on, global_irq_enable, irq_vector_ack;
  logic                 comparator_irq_req, irq;
  logic [7:0]           s_axi_awaddr, s_axi_araddr, pos_v;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]          s_axi_wdata, s_axi_rdata, d;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp, channel_select, r;
  ccl_pkg::ccl_analog_s analog_ctl;
  ccl_pkg::ccl_pins_s   pin_in;
  ccl_pkg::ccl_pins_s   pin_port;
  int                   err_total, total_checks;
  // ==========================================================
  // Design and comparator core
  ccl_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw, .converter_on,
    .channel_select, .analog_ctl, .pin_in, .pin_port, .global_irq_enable, .irq_vector_ack,
    .comparator_irq_req, .irq);
  ccl_cmp_model core_u (.analog_ctl, .pos_v, .neg_v(8'h50), .chan_v(32'h40302010), .cmp_raw);
  always #2 aclk = ~aclk;
  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic pa, pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      pa = s_axi_awvalid && !s_axi_awready;
      pw = s_axi_wvalid && !s_axi_wready;
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end while (pa || pw);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk("bresp", 32'(rs), 32'(ccl_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk("rdata", v, {24'h0, e});
    chk("rresp", 32'(rs), 32'(er));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
  endtask
  // ==========================================================
  // Watchdog: the full run needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {aclk, aresetn, converter_on, global_irq_enable, irq_vector_ack, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pos_v, channel_select, pin_in} = '0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    total_checks = 0;
    do_reset();
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      converter_on <= ROWS[i].on;
      channel_select <= ROWS[i].ch;
      pos_v <= ROWS[i].pos;
      wr_ok(ccl_pkg::OFF_CONV_B, ROWS[i].convb);
      wr_ok(ccl_pkg::OFF_CMP_CTRL, ROWS[i].ctrl);
      cyc(6);
      chk("route", 32'(analog_ctl[4:2]), 32'(ROWS[i].an));
      rd(ccl_pkg::OFF_CMP_CTRL, d, r);
      chk("result", 32'(d[5]), 32'(ROWS[i].res));
      rd_chk(ccl_pkg::OFF_CONV_B, ROWS[i].convb, ccl_pkg::RESP_OKAY);
    end
    pos_v <= 8'h00;
    converter_on <= 1'b0;
    do_reset();
    cyc(4);
    chk("outs", 32'({analog_ctl, pin_port, irq, comparator_irq_req}), 32'h0);
    for (int k = 0; k < 5; k++) rd_chk(8'(4 * k), 8'h00, ccl_pkg::RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      // Interrupt enable stays clear while the mode changes
      wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'(m));
      cyc(6);
      wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h10 | 8'(m));
      pos_v <= 8'h60;
      cyc(6);
      rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'h20 | 8'(m) | ((m == 0 || m == 3) ? 8'h10 : 8'h00), 2'h0);
      wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h10 | 8'(m));
      pos_v <= 8'h00;
      cyc(6);
      rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'(m) | ((m == 0 || m == 2) ? 8'h10 : 8'h00), 2'h0);
    end
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h10);
    rd(ccl_pkg::OFF_IRQ_STAT, d, r);
    wr_ok(ccl_pkg::OFF_IRQ_MASK, 8'h01);
    pos_v <= 8'h60;
    cyc(6);
    chk("irq", 32'(irq), 32'h1);
    rd_chk(ccl_pkg::OFF_IRQ_STAT, 8'h03, ccl_pkg::RESP_OKAY);
    cyc(1);
    chk("irq", 32'(irq), 32'h0);
    wr_ok(ccl_pkg::OFF_IRQ_MASK, 8'h00);
    pos_v <= 8'h00;
    cyc(6);
    chk("irq", 32'(irq), 32'h0);
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h08);
    rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'h18, ccl_pkg::RESP_OKAY);
    chk("req", 32'(comparator_irq_req), 32'h0);
    global_irq_enable <= 1'b1;
    cyc(2);
    chk("req", 32'(comparator_irq_req), 32'h1);
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h00);
    chk("req", 32'(comparator_irq_req), 32'h0);
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h08);
    irq_vector_ack <= 1'b1;
    cyc(1);
    irq_vector_ack <= 1'b0;
    cyc(1);
    chk("req", 32'(comparator_irq_req), 32'h0);
    rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'h08, ccl_pkg::RESP_OKAY);
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h00);
    pos_v <= 8'h60;
    cyc(6);
    // Power down with the output high: the falling level must not raise the flag
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h90);
    cyc(3);
    chk("power", 32'(analog_ctl.power_off), 32'h1);
    cyc(6);
    rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'h80, ccl_pkg::RESP_OKAY);
    pos_v <= 8'h00;
    cyc(6);
    wr_ok(ccl_pkg::OFF_CMP_CTRL, 8'h04);
    cyc(6);
    rd_chk(ccl_pkg::OFF_CMP_CTRL, 8'h00, ccl_pkg::RESP_OKAY);
    pin_in <= 2'b11;
    wr_ok(ccl_pkg::OFF_DIN_DIS, 8'h03);
    cyc(2);
    chk("pins", 32'(pin_port), 32'h0);
    wr_ok(ccl_pkg::OFF_DIN_DIS, 8'h01);
    cyc(2);
    chk("pins", 32'(pin_port), 32'h2);
    rd_chk(ccl_pkg::OFF_DIN_DIS, 8'h01, ccl_pkg::RESP_OKAY);
    wr(8'h14, 8'hFF, r);
    chk("bresp", 32'(r), 32'(ccl_pkg::RESP_SLVERR));
    rd_chk(8'h14, 8'h00, ccl_pkg::RESP_SLVERR);
    test_done();
  end
endmodule
